// ==== include/seed_pkg.sv ====
// Constants shared by the two-wire serial memory target.
// Assumes one clock domain; the serial pins are sampled by that clock.
package seed_pkg;
    // Device address prefixes, upper six bits of the address byte.
    localparam logic [5:0] DEV_MAIN_PFX = 6'h28;
    localparam logic [5:0] DEV_ALT_PFX = 6'h2C;
    // Word address prefixes, bits 7:6, for the alternate block.
    localparam logic [1:0] WRD_SEC_PFX = 2'h0;
    localparam logic [1:0] WRD_UID_PFX = 2'h2;
    // Array geometry.
    localparam int MAIN_BYTES = 512;
    localparam int PAGE_BYTES = 16;
    localparam int SIDE_BYTES = 16;
    // Reset value and bits per byte.
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Arbitrary neutral identifier value, not any real part's.
    localparam logic [127:0] UID_DEFAULT =
        128'h0123456789ABCDEF0F1E2D3C4B5A6978;
    // FIFO entry: allow flag, region, address, data.
    localparam int ENTRY_W = 20;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef enum logic [1:0] {
        SEED_RGN_MAIN = 2'b00,
        SEED_RGN_SEC = 2'b01,
        SEED_RGN_UID = 2'b10
    } seed_region_t;

    typedef enum logic [3:0] {
        SEED_ST_IDLE = 4'b0000,
        SEED_ST_DEV = 4'b0001,
        SEED_ST_DEV_ACK = 4'b0010,
        SEED_ST_WORD = 4'b0011,
        SEED_ST_WORD_ACK = 4'b0100,
        SEED_ST_WDATA = 4'b0101,
        SEED_ST_WDATA_ACK = 4'b0110,
        SEED_ST_RDATA = 4'b0111,
        SEED_ST_RACK = 4'b1000
    } seed_state_t;
endpackage

// ==== verilog/seed_target.sv ====
// Two-wire bus target with address decode, write protect and storage.
// Assumes the serial clock, data and control pins are asynchronous.
//
// Operation
// (RULE_01) Sample data on rise, change on fall.
// (RULE_02) Data line only pulled low or released.
// (RULE_03) Master expects one such device per bus.
// (RULE_04) Write protect high blocks every write.
// (RULE_05) Write protect low or open allows writes.
// (RULE_06) Master holds write protect steady per write.
// (RULE_07) Write protect change voids that write; bytes taken before a rise to high still commit.
// (RULE_08) Main array: 32 pages, 9-bit address.
// (RULE_09) Security sector writable until locked, then read-only.
// (RULE_10) Identifier block chosen by address nibble 1011.
// (RULE_11) Main address byte 101000 plus page, direction.
// (RULE_12) Page from page bit and word bits 7:4.
// (RULE_13) Sector selected when word bits 7:6 are 00.
// (RULE_14) Identifier read with word bits 7:6 at 10.
// (RULE_15) Page write wraps offset inside its page.
`timescale 1ns/1ps
module seed_target
    import seed_pkg::*;
#(
    parameter logic [127:0] UID_VALUE = UID_DEFAULT
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Serial bus pins.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Control pins.
    input wire logic wp_i,
    input wire logic lock_sector_i,
    output logic sector_locked_o,
    // Accepted write stream.
    output logic mon_valid_o,
    output logic mon_allow_o,
    output logic [1:0] mon_region_o,
    output logic [8:0] mon_addr_o,
    output logic [7:0] mon_data_o,
    input wire logic mon_ready_i
);
    logic [2:0] scl_reg, sda_reg;
    logic [1:0] wp_reg, lk_reg;
    seed_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next, tx_reg, tx_next;
    logic rw_reg, rw_next, ack_ok_reg, ack_ok_next;
    logic [1:0] rgn_reg, rgn_next;
    logic [8:0] addr_reg, addr_next;
    logic wp_lat_reg, wp_lat_next, oe_reg, oe_next;
    logic locked_reg, push;
    logic [ENTRY_W-1:0] head_reg, tail_reg, head_next, tail_next, entry;
    logic [1:0] count_reg, count_next;
    logic [7:0] mem_reg [0:MAIN_BYTES-1];
    logic [7:0] sec_reg [0:SIDE_BYTES-1];

    function automatic logic [8:0] wrap_offset(input logic [8:0] a);
        wrap_offset = {a[8:4], a[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] uid_byte(input logic [3:0] i);
        uid_byte = UID_VALUE[8'd127 - {i, 3'b000} -: 8];
    endfunction

    wire scl_s = scl_reg[1];
    wire scl_d = scl_reg[2];
    wire sda_s = sda_reg[1];
    wire sda_d = sda_reg[2];
    wire wp_s = wp_reg[1];
    // (RULE_01) Edge detection on sampled clock.
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
    wire byte_done = scl_fall & (cnt_reg == BITS_PER_BYTE);
    // (RULE_10) Address byte decode.
    wire dev_main = sh_reg[7:2] == DEV_MAIN_PFX;
    wire dev_alt = sh_reg[7:2] == DEV_ALT_PFX;
    wire wrd_sec = sh_reg[7:6] == WRD_SEC_PFX;
    wire wrd_uid = sh_reg[7:6] == WRD_UID_PFX;
    wire fifo_can = count_reg != FIFO_DEPTH;
    wire pop = (count_reg != 2'h0) & mon_ready_i;
    wire head_allow = head_reg[ENTRY_W-1];
    wire [1:0] head_rgn = head_reg[18:17];
    wire [8:0] head_addr = head_reg[16:8];
    // (RULE_04) Write permission gating.
    // (RULE_05) Low protect level permits writes.
    wire allow = ~wp_lat_reg & ~wp_s
        & ~((rgn_reg == SEED_RGN_SEC) & locked_reg);
    wire [7:0] rd_byte = (rgn_reg == SEED_RGN_MAIN) ? mem_reg[addr_reg] :
        (rgn_reg == SEED_RGN_SEC) ? sec_reg[addr_reg[3:0]] :
        uid_byte(addr_reg[3:0]);
    assign entry = {allow, rgn_reg, addr_reg, sh_reg};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_reg <= 3'h7;
            sda_reg <= 3'h7;
            wp_reg <= 2'h0;
            lk_reg <= 2'h0;
        end else begin
            scl_reg <= {scl_reg[1:0], scl_i};
            sda_reg <= {sda_reg[1:0], sda_i};
            wp_reg <= {wp_reg[0], wp_i};
            lk_reg <= {lk_reg[0], lock_sector_i};
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        tx_next = tx_reg;
        rw_next = rw_reg;
        ack_ok_next = ack_ok_reg;
        rgn_next = rgn_reg;
        addr_next = addr_reg;
        wp_lat_next = wp_lat_reg;
        oe_next = oe_reg;
        push = 1'b0;
        if (stop_det) begin
            state_next = SEED_ST_IDLE;
            oe_next = 1'b0;
        end else if (start_det) begin
            state_next = SEED_ST_DEV;
            cnt_next = 4'h0;
            oe_next = 1'b0;
            // (RULE_07) Latch protect level at start.
            wp_lat_next = wp_s;
        end else begin
            if (scl_rise && (state_reg == SEED_ST_DEV
                || state_reg == SEED_ST_WORD
                || state_reg == SEED_ST_WDATA)) begin
                // (RULE_01) Shift on rising edge.
                sh_next = {sh_reg[6:0], sda_s};
                cnt_next = cnt_reg + 4'h1;
            end
            case (state_reg)
                SEED_ST_DEV: begin
                    if (byte_done) begin
                        cnt_next = 4'h0;
                        // (RULE_11) Match address and take page bit.
                        if (dev_main) begin
                            rgn_next = SEED_RGN_MAIN;
                            addr_next = {sh_reg[1], addr_reg[7:0]};
                        end else if (dev_alt && rgn_reg == SEED_RGN_MAIN) begin
                            rgn_next = SEED_RGN_SEC;
                        end
                        rw_next = sh_reg[0];
                        oe_next = dev_main | dev_alt;
                        state_next = (dev_main | dev_alt) ?
                            SEED_ST_DEV_ACK : SEED_ST_IDLE;
                    end
                end
                SEED_ST_DEV_ACK: begin
                    if (scl_fall) begin
                        cnt_next = 4'h0;
                        tx_next = rd_byte;
                        oe_next = rw_reg & ~rd_byte[7];
                        state_next = rw_reg ? SEED_ST_RDATA : SEED_ST_WORD;
                    end
                end
                SEED_ST_WORD: begin
                    if (byte_done) begin
                        cnt_next = 4'h0;
                        oe_next = 1'b1;
                        state_next = SEED_ST_WORD_ACK;
                        // (RULE_12) Page and offset from word.
                        if (rgn_reg == SEED_RGN_MAIN) begin
                            addr_next = {addr_reg[8], sh_reg};
                        // (RULE_13) Sector window select.
                        end else if (wrd_sec) begin
                            rgn_next = SEED_RGN_SEC;
                            addr_next = {5'h00, sh_reg[3:0]};
                        // (RULE_14) Identifier window select.
                        end else if (wrd_uid) begin
                            rgn_next = SEED_RGN_UID;
                            addr_next = {5'h00, sh_reg[3:0]};
                        end else begin
                            oe_next = 1'b0;
                            state_next = SEED_ST_IDLE;
                        end
                    end
                end
                SEED_ST_WORD_ACK, SEED_ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        state_next = SEED_ST_WDATA;
                    end
                end
                SEED_ST_WDATA: begin
                    if (byte_done) begin
                        cnt_next = 4'h0;
                        // (RULE_14) Identifier refuses data writes.
                        if (fifo_can && rgn_reg != SEED_RGN_UID) begin
                            push = 1'b1;
                            oe_next = 1'b1;
                            // (RULE_15) Offset wraps within page.
                            addr_next = wrap_offset(addr_reg);
                            state_next = SEED_ST_WDATA_ACK;
                        end else begin
                            state_next = SEED_ST_IDLE;
                        end
                    end
                end
                SEED_ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                    if (byte_done) begin
                        oe_next = 1'b0;
                        cnt_next = 4'h0;
                        state_next = SEED_ST_RACK;
                    end else if (scl_fall) begin
                        // (RULE_01) Next bit after falling edge.
                        tx_next = {tx_reg[6:0], 1'b0};
                        oe_next = ~tx_reg[6];
                    end
                end
                SEED_ST_RACK: begin
                    if (scl_rise) begin
                        ack_ok_next = ~sda_s;
                        addr_next = (rgn_reg == SEED_RGN_MAIN) ?
                            addr_reg + 9'h001 : wrap_offset(addr_reg);
                    end
                    if (scl_fall) begin
                        tx_next = rd_byte;
                        oe_next = ack_ok_reg & ~rd_byte[7];
                        state_next = ack_ok_reg ?
                            SEED_ST_RDATA : SEED_ST_IDLE;
                    end
                end
                default: begin
                    state_next = SEED_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= SEED_ST_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            rw_reg <= 1'b0;
            ack_ok_reg <= 1'b0;
            rgn_reg <= SEED_RGN_MAIN;
            addr_reg <= 9'h000;
            wp_lat_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            tx_reg <= tx_next;
            rw_reg <= rw_next;
            ack_ok_reg <= ack_ok_next;
            rgn_reg <= rgn_next;
            addr_reg <= addr_next;
            wp_lat_reg <= wp_lat_next;
            oe_reg <= oe_next;
        end
    end

    // Two-entry write buffer; head is presented on the stream.
    always_comb begin
        head_next = head_reg;
        tail_next = tail_reg;
        count_next = count_reg;
        if (pop && push) begin
            head_next = (count_reg == 2'h1) ? entry : tail_reg;
            tail_next = entry;
        end else if (pop) begin
            head_next = tail_reg;
            count_next = count_reg - 2'h1;
        end else if (push) begin
            head_next = (count_reg == 2'h0) ? entry : head_reg;
            tail_next = entry;
            count_next = count_reg + 2'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            head_reg <= '0;
            tail_reg <= '0;
            count_reg <= 2'h0;
            locked_reg <= 1'b0;
        end else begin
            head_reg <= head_next;
            tail_reg <= tail_next;
            count_reg <= count_next;
            // (RULE_09) Lock stays set once set; only reset clears it.
            locked_reg <= locked_reg | lk_reg[1];
        end
    end

    // (RULE_08) Storage commit on stream handshake.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < MAIN_BYTES; i++) begin
                mem_reg[i] <= ERASED_BYTE;
            end
            for (int j = 0; j < SIDE_BYTES; j++) begin
                sec_reg[j] <= ERASED_BYTE;
            end
        end else if (pop && head_allow) begin
            if (head_rgn == SEED_RGN_MAIN) begin
                mem_reg[head_addr] <= head_reg[7:0];
            end else if (head_rgn == SEED_RGN_SEC) begin
                sec_reg[head_addr[3:0]] <= head_reg[7:0];
            end
        end
    end

    // (RULE_02) Open-drain drive, low only.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            sector_locked_o <= 1'b0;
            mon_valid_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            sda_oe_o <= oe_next;
            sector_locked_o <= locked_reg | lk_reg[1];
            mon_valid_o <= count_next != 2'h0;
        end
    end
    assign mon_allow_o = head_allow;
    assign mon_region_o = head_rgn;
    assign mon_addr_o = head_addr;
    assign mon_data_o = head_reg[7:0];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_read_end;
        state_reg == SEED_ST_RDATA && byte_done;
    endsequence
    property p_shift_on_rise;
        $changed(cnt_reg) && state_reg == SEED_ST_DEV && cnt_reg != 4'h0
            |-> $past(scl_rise);
    endproperty
    a_shift_on_rise: assert property (p_shift_on_rise) // RULE_01
        else $error("bit counted without a rising clock edge");
    property p_oe_after_fall;
        $rose(sda_oe_o) |-> $past(scl_fall);
    endproperty
    a_oe_after_fall: assert property (p_oe_after_fall) // RULE_01
        else $error("data line driven without a falling clock edge");
    property p_read_release;
        s_read_end |=> !sda_oe_o;
    endproperty
    a_read_release: assert property (p_read_release) // RULE_02
        else $error("data line held after the last read bit");
    property p_low_only;
        sda_oe_o |-> !sda_o;
    endproperty
    a_low_only: assert property (p_low_only) // RULE_02
        else $error("data line driven high");
    property p_wp_blocks;
        push && (wp_s || wp_lat_reg) |=> !tail_reg[ENTRY_W-1];
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) // RULE_04
        else $error("write accepted while protected");
    property p_wp_low_allows;
        push && !wp_s && !wp_lat_reg && rgn_reg == SEED_RGN_MAIN
            |=> tail_reg[ENTRY_W-1];
    endproperty
    a_wp_low_allows: assert property (p_wp_low_allows) // RULE_05
        else $error("unprotected main write refused");
    property p_lock_refuses;
        push && locked_reg && rgn_reg == SEED_RGN_SEC
            |=> !tail_reg[ENTRY_W-1];
    endproperty
    a_lock_refuses: assert property (p_lock_refuses) // RULE_09
        else $error("write accepted into locked sector");
    property p_dev_match;
        state_reg == SEED_ST_DEV && state_next == SEED_ST_DEV_ACK
            |-> sh_reg[7:2] == DEV_MAIN_PFX || sh_reg[7:2] == DEV_ALT_PFX;
    endproperty
    a_dev_match: assert property (p_dev_match) // RULE_11
        else $error("acknowledged a foreign address byte");
    property p_uid_window;
        $rose(rgn_reg == SEED_RGN_UID) |-> $past(sh_reg[7:6]) == WRD_UID_PFX
            && addr_reg[8:4] == 5'h00;
    endproperty
    a_uid_window: assert property (p_uid_window) // RULE_14
        else $error("identifier selected by a wrong word address");
    property p_page_wrap;
        push && rgn_reg == SEED_RGN_MAIN
            |=> addr_reg[8:4] == $past(addr_reg[8:4])
            && addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1;
    endproperty
    a_page_wrap: assert property (p_page_wrap) // RULE_15
        else $error("page write left its page");
endmodule

// ==== tb/seed_master.sv ====
// Two-wire bus master model: serial clock and open-drain data pull.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module seed_master (
    // Clock.
    input wire logic mclk_i,
    // Resolved data line.
    input wire logic sda_i,
    // Bus drive.
    output logic scl_o,
    output logic sda_pull_o
);
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic tick();
        repeat (8) @(posedge mclk_i);
        #1;
    endtask
    task automatic start();
        sda_pull_o = 1'b0;
        tick();
        scl_o = 1'b1;
        tick();
        sda_pull_o = 1'b1;
        tick();
        scl_o = 1'b0;
        tick();
    endtask
    task automatic stop();
        sda_pull_o = 1'b1;
        tick();
        scl_o = 1'b1;
        tick();
        sda_pull_o = 1'b0;
        tick();
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_pull_o = ~b;
        tick();
        scl_o = 1'b1;
        tick();
        r = sda_i;
        tick();
        scl_o = 1'b0;
        tick();
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], r);
        end
        bitx(1'b1, ack);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            b[i] = r;
        end
        bitx(last, r);
    endtask
endmodule

// ==== tb/serial_eeprom_addr_decode_wp_tb.sv ====
// Self-checking bench for the two-wire memory target.
// Assumes the master model in seed_master and a pulled-up data line.
`timescale 1ns/1ps
module serial_eeprom_addr_decode_wp_tb;
    import seed_pkg::*;
    localparam logic [127:0] UID_T = 128'h00112233445566778899AABBCCDDEEFF;
    logic mclk, rst_n, scl, sda, m_pull, wp, lock, ready;
    logic sda_o, sda_oe, locked, mv, mal, scl_d, oe_d;
    logic [1:0] mrg;
    logic [8:0] mad;
    logic [7:0] mdt;
    logic mv_d;
    logic [19:0] hold;
    int bad_count = 0;
    int checked = 0;
    logic [31:0] rs = 32'h55;
    logic [7:0] mem [512];
    logic [7:0] sec [16];
    logic [7:0] dq [16];
    logic [19:0] q [$];
    logic [7:0] bad_dev [4] = '{8'hA8, 8'hA4, 8'h50, 8'hB8};
    assign sda = ~(m_pull | (sda_oe & ~sda_o));
    seed_target #(.UID_VALUE(UID_T)) dut (.mclk_i(mclk), .rst_n_i(rst_n),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .wp_i(wp), .lock_sector_i(lock), .sector_locked_o(locked),
        .mon_valid_o(mv), .mon_allow_o(mal), .mon_region_o(mrg),
        .mon_addr_o(mad), .mon_data_o(mdt), .mon_ready_i(ready));
    seed_master m (.mclk_i(mclk), .sda_i(sda), .scl_o(scl),
        .sda_pull_o(m_pull));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    function automatic logic [7:0] exp_byte(logic [1:0] rg, logic [8:0] a);
        if (rg == 2'h0) return mem[a];
        if (rg == 2'h1) return sec[a[3:0]];
        return UID_T[127 - 8 * a[3:0] -: 8];
    endfunction
    function automatic logic [19:0] ent(logic al, logic [1:0] rg,
        logic [8:0] a, logic [7:0] d);
        return {al, rg, a, d};
    endfunction
    task automatic chk_ack(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_val(input string nm, input logic [19:0] e,
        input logic [19:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic send(input logic [7:0] b, input logic e);
        logic a;
        m.wbyte(b, a);
        chk_ack("ack", e, a);
    endtask
    task automatic wr(input logic [7:0] dv, input logic [7:0] wa,
        input int n, input int ok);
        m.start();
        send(dv, 1'b0);
        send(wa, 1'b0);
        for (int i = 0; i < n; i++) begin
            dq[i] = 8'(rnd());
            send(dq[i], i >= ok);
        end
        m.stop();
    endtask
    task automatic readback(input logic [7:0] dw, input logic [7:0] wa,
        input logic [7:0] dr, input int n, input logic [1:0] rg,
        input logic [8:0] base);
        logic [7:0] b;
        m.start();
        send(dw, 1'b0);
        send(wa, 1'b0);
        m.start();
        send(dr, 1'b0);
        for (int i = 0; i < n; i++) begin
            m.rbyte(i == n - 1, b);
            chk_val("rdata", 20'(exp_byte(rg, base + 9'(i))),
                20'(b));
        end
        m.stop();
    endtask
    task automatic expect_w(input logic [1:0] rg, input logic [8:0] base,
        input int n, input logic al);
        logic [19:0] g;
        logic [8:0] a;
        for (int i = 0; i < n; i++) begin
            a = {base[8:4], 4'(base[3:0] + 4'(i))};
            for (int k = 0; k < 2000 && q.size() == 0; k++) cyc(1);
            g = (q.size() > 0) ? q.pop_front() : 20'hFFFFF;
            chk_val("entry", ent(al, rg, a, dq[i]), g);
            if (al && rg == 2'h0) mem[a] = dq[i];
            if (al && rg == 2'h1) sec[a[3:0]] = dq[i];
        end
    endtask
    always @(posedge mclk) begin
        scl_d <= scl;
        oe_d <= sda_oe;
        mv_d <= mv & ~ready;
        hold <= {mal, mrg, mad, mdt};
        if (rst_n && mv_d && {mal, mrg, mad, mdt} !== hold) begin
            chk_val("stand", hold, {mal, mrg, mad, mdt});
        end
        if (rst_n && mv && ready) begin
            q.push_back({mal, mrg, (mrg == 2'h1) ? {5'h0, mad[3:0]} : mad,
                mdt});
        end
        if (rst_n && scl && scl_d && sda_oe !== oe_d) begin
            chk_ack("oe_hold", oe_d, sda_oe);
        end
        if (sda_oe === 1'b1 && sda_o !== 1'b0) begin
            chk_ack("sda_o", 1'b0, sda_o);
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge mclk);
        bad_count++;
        test_done();
    end
    initial begin
        logic [8:0] a;
        logic [7:0] w;
        rst_n = 1'b0;
        wp = 1'b0;
        lock = 1'b0;
        ready = 1'b1;
        foreach (mem[i]) mem[i] = ERASED_BYTE;
        foreach (sec[i]) sec[i] = ERASED_BYTE;
        cyc(12);
        rst_n = 1'b1;
        cyc(3);
        chk_ack("oe_rst", 1'b0, sda_oe);
        chk_ack("lock_rst", 1'b0, locked);
        for (int j = 0; j < 5; j++) begin
            a = (j == 0) ? 9'h0FF : 9'(rnd());
            wr({6'h28, a[8], 1'b0}, a[7:0], 1, 1);
            expect_w(2'h0, a, 1, 1'b1);
            readback({6'h28, a[8], 1'b0}, a[7:0], {6'h28, a[8], 1'b1}, 2,
                2'h0, a);
        end
        $display("test main_byte done");
        a = {5'(rnd()), 4'hE};
        wr({6'h28, a[8], 1'b0}, a[7:0], 4, 4);
        expect_w(2'h0, a, 4, 1'b1);
        readback({6'h28, a[8], 1'b0}, {a[7:4], 4'h0}, {6'h28, a[8], 1'b1},
            2, 2'h0, {a[8:4], 4'h0});
        ready = 1'b0;
        wr({6'h28, a[8], 1'b0}, a[7:0], 3, 2);
        chk_val("stall_q", 20'h0, 20'(q.size()));
        cyc(20);
        ready = 1'b1;
        expect_w(2'h0, a, 2, 1'b1);
        $display("test page_stall done");
        wp = 1'b1;
        wr({6'h28, a[8], 1'b0}, a[7:0], 1, 1);
        expect_w(2'h0, a, 1, 1'b0);
        wp = 1'b0;
        readback({6'h28, a[8], 1'b0}, a[7:0], {6'h28, a[8], 1'b1}, 1,
            2'h0, a);
        $display("test protect done");
        w = {2'b00, 2'(rnd()), 4'hF};
        wr(8'hB2, w, 2, 2);
        expect_w(2'h1, 9'h00F, 2, 1'b1);
        readback(8'hB0, w, 8'hB1, 2, 2'h1, 9'h00F);
        lock = 1'b1;
        cyc(4);
        lock = 1'b0;
        cyc(4);
        chk_ack("locked", 1'b1, locked);
        wr(8'hB0, w, 1, 1);
        expect_w(2'h1, 9'h00F, 1, 1'b0);
        readback(8'hB0, w, 8'hB3, 1, 2'h1, 9'h00F);
        m.start();
        send(8'hB0, 1'b0);
        send(8'h40, 1'b1);
        m.stop();
        $display("test sector done");
        w = {2'b10, 2'(rnd()), 4'hF};
        readback(8'hB0, w, 8'hB3, 3, 2'h2, 9'h00F);
        wr(8'hB0, 8'h80, 1, 0);
        foreach (bad_dev[i]) begin
            m.start();
            send(bad_dev[i], 1'b1);
            m.stop();
        end
        chk_val("q_end", 20'h0, 20'(q.size()));
        $display("test identifier done");
        test_done();
    end
endmodule
